// [rtl/ustep_pkg.sv]
/*
  shared constants and types for the microstep command receiver and bridge protection.
  assumes a 12-bit coil word sent msb first, coil a field in the upper six bits.
*/
package ustep_pkg;

  // ----------------------------------------------------------------
  // serial word framing
  // ----------------------------------------------------------------
  localparam int         WORD_BITS    = 12;
  localparam int         BIT_CNT_W    = 4;
  localparam logic [3:0] BIT_CNT_LAST = 4'hB;
  localparam logic [3:0] BIT_CNT_FULL = 4'hC;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE  = 4'h1;

  // ----------------------------------------------------------------
  // coil field layout
  // ----------------------------------------------------------------
  localparam int          MAG_BITS           = 4;
  localparam logic [3:0]  MAG_ZERO           = 4'h0;
  localparam logic [11:0] WORD_ZERO          = 12'h000;
  localparam logic [11:0] DECAY_REVERSE_MASK = 12'h820;

  typedef struct packed {
    logic                mixed_decay;
    logic [MAG_BITS-1:0] magnitude;
    logic                polarity;
  } coil_field_t;

  typedef struct packed {
    coil_field_t coil_a;
    coil_field_t coil_b;
  } coil_word_t;

  // ----------------------------------------------------------------
  // overcurrent flags and step counter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic low_a;
    logic low_b;
    logic high;
  } oc_flags_t;

  localparam int          OC_BITS      = 3;
  localparam logic [2:0]  OC_NONE      = 3'h0;
  localparam int          STEP_CNT_W   = 16;
  localparam logic [15:0] STEP_CNT_ONE = 16'h0001;
  localparam logic [15:0] STEP_CNT_ZERO = 16'h0000;
  localparam int          PIN_SYNC_W   = 6;

  // ----------------------------------------------------------------
  // drive state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_RUN = 3'h2,
    ST_HOT = 3'h4
  } drive_state_t;

endpackage : ustep_pkg

// [rtl/sync_2ff.sv]
/*
  two flip-flop level synchroniser, any width.
  assumes each bit is a level that stays put for at least two destination clocks.
*/
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_meta = d_in;
    next_q    = meta;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= next_meta;
      q_out <= next_q;
    end
  end

endmodule : sync_2ff

// [rtl/spi_word_rx.sv]
/*
  serial shifter on the link clock: takes twelve bits msb first while chip select is low.
  assumes mode 0 sampling on the rising clock edge; the clock may stop outside frames.
*/
`timescale 1ns/1ps
module spi_word_rx
  import ustep_pkg::*;
(
  input  wire logic spi_sck_in,
  input  wire logic spi_cs_n_in,
  input  wire logic spi_mosi_in,
  input  wire logic rstn_in,
  output coil_word_t word_out,
  output logic       word_toggle_out
);

  logic [WORD_BITS-1:0] shift;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [WORD_BITS-1:0] next_shift;
  logic [BIT_CNT_W-1:0] next_bit_cnt;
  coil_word_t           next_word;
  logic                 next_toggle;

  // ----------------------------------------------------------------
  // bit collection
  // ----------------------------------------------------------------
  always_comb
  begin
    next_shift   = {shift[WORD_BITS-2:0], spi_mosi_in};
    next_bit_cnt = bit_cnt;
    next_word    = word_out;
    next_toggle  = word_toggle_out;
    if (bit_cnt != BIT_CNT_FULL)
    begin
      next_bit_cnt = bit_cnt + BIT_CNT_ONE;
    end
    if (bit_cnt == BIT_CNT_LAST)
    begin
      next_word   = next_shift;
      next_toggle = ~word_toggle_out;
    end
  end

  // frame end clears the bit counter; a short frame is dropped
  always_ff @(posedge spi_sck_in or posedge spi_cs_n_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bit_cnt <= BIT_CNT_ZERO;
    end
    else if (spi_cs_n_in)
    begin
      bit_cnt <= BIT_CNT_ZERO;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(posedge spi_sck_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      shift           <= WORD_ZERO;
      word_out        <= WORD_ZERO;
      word_toggle_out <= 1'b0;
    end
    else
    begin
      shift           <= next_shift;
      word_out        <= next_word;
      word_toggle_out <= next_toggle;
    end
  end

endmodule : spi_word_rx

// [rtl/microstep_spi_command_and_protection.sv]
/*
  microstep command receiver with thermal, disable and overcurrent protection.
  assumes pins are asynchronous to ref_clk_in and words end at least 200 ns apart.
*/
`timescale 1ns/1ps
// Functional notes
// - overtemperature present: all bridge power transistors are off
// - overtemperature gone: bridges resume by themselves, no command needed
// - overtemperature flag is reported; controller watches it
// - separate pre-warning flag is reported; controller may lower current
// - disabled: all transistors off, low-current shutdown state
// - entering disable clears every coil register and every flag to zero
// - each received word is exactly one microstep; words received while disabled are dropped and make no step
// - coil magnitude sits above bit 0 of its six-bit field
// - bit 0 of each coil field is the coil polarity
// - bit 5 of each coil field selects mixed decay
// - word with both magnitudes zero clears the overcurrent flags
module microstep_spi_command_and_protection
  import ustep_pkg::*;
(
  input  wire logic      ref_clk_in,
  input  wire logic      rstn_in,
  input  wire logic      spi_sck_in,
  input  wire logic      spi_cs_n_in,
  input  wire logic      spi_mosi_in,
  input  wire logic      disable_input_low_active_in,
  input  wire logic      overtemp_in,
  input  wire logic      prewarn_in,
  input  wire oc_flags_t oc_event_in,
  output coil_field_t    coil_a_out,
  output coil_field_t    coil_b_out,
  output logic           bridge_a_on_out,
  output logic           bridge_b_on_out,
  output logic           shutdown_out,
  output logic           overtemp_flag_out,
  output logic           prewarn_flag_out,
  output oc_flags_t      oc_flags_out,
  output logic           step_pulse_out,
  output logic [15:0]    step_count_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic coil_zero(input coil_field_t f);
    coil_zero = (f.magnitude == MAG_ZERO);
  endfunction : coil_zero

  function automatic logic bridge_drive(input drive_state_t st,
                                        input coil_field_t  f,
                                        input logic         oc_low,
                                        input logic         oc_high);
    bridge_drive = (st == ST_RUN) && !coil_zero(f) && !oc_low && !oc_high;
  endfunction : bridge_drive

  // ----------------------------------------------------------------
  // link side and crossings
  // ----------------------------------------------------------------
  coil_word_t            rx_word;
  logic                  rx_toggle;
  logic                  toggle_sync;
  logic [PIN_SYNC_W-1:0] pins_sync;
  logic                  dis_s;
  logic                  ot_s;
  logic                  pw_s;
  oc_flags_t             oc_s;
  logic                  toggle_prev;
  logic                  word_take;

  spi_word_rx u_rx (
    .spi_sck_in      (spi_sck_in),
    .spi_cs_n_in     (spi_cs_n_in),
    .spi_mosi_in     (spi_mosi_in),
    .rstn_in         (rstn_in),
    .word_out        (rx_word),
    .word_toggle_out (rx_toggle)
  );

  sync_2ff #(
    .WIDTH (1)
  ) u_tog_sync (
    .clk_in  (ref_clk_in),
    .rstn_in (rstn_in),
    .d_in    (rx_toggle),
    .q_out   (toggle_sync)
  );

  sync_2ff #(
    .WIDTH (PIN_SYNC_W)
  ) u_pin_sync (
    .clk_in  (ref_clk_in),
    .rstn_in (rstn_in),
    .d_in    ({disable_input_low_active_in, overtemp_in, prewarn_in, oc_event_in}),
    .q_out   (pins_sync)
  );

  assign dis_s     = pins_sync[PIN_SYNC_W-1];
  assign ot_s      = pins_sync[PIN_SYNC_W-2];
  assign pw_s      = pins_sync[PIN_SYNC_W-3];
  assign oc_s      = pins_sync[OC_BITS-1:0];
  assign word_take = toggle_sync ^ toggle_prev;

  // ----------------------------------------------------------------
  // drive state and outputs
  // ----------------------------------------------------------------
  drive_state_t state;
  drive_state_t next_state;
  logic         next_toggle_prev;
  coil_field_t  next_coil_a;
  coil_field_t  next_coil_b;
  logic         next_bridge_a;
  logic         next_bridge_b;
  logic         next_shutdown;
  logic         next_ot_flag;
  logic         next_pw_flag;
  oc_flags_t    next_oc;
  logic         next_step_pulse;
  logic [15:0]  next_step_count;

  localparam coil_word_t CLEAR_WORD = WORD_ZERO;

  always_comb
  begin
    next_state       = state;
    next_toggle_prev = toggle_sync;
    next_coil_a      = coil_a_out;
    next_coil_b      = coil_b_out;
    next_ot_flag     = ot_s;
    next_pw_flag     = pw_s;
    next_oc          = oc_flags_out;
    next_step_pulse  = 1'b0;
    next_step_count  = step_count_out;
    unique case (state)
      ST_OFF:
      begin
        if (!dis_s)
        begin
          next_state = ot_s ? ST_HOT : ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (dis_s)
        begin
          next_state = ST_OFF;
        end
        else if (ot_s)
        begin
          next_state = ST_HOT;
        end
      end
      ST_HOT:
      begin
        if (dis_s)
        begin
          next_state = ST_OFF;
        end
        else if (!ot_s)
        begin
          next_state = ST_RUN;
        end
      end
    endcase
    if (dis_s)
    begin
      next_coil_a     = CLEAR_WORD.coil_a;
      next_coil_b     = CLEAR_WORD.coil_b;
      next_ot_flag    = 1'b0;
      next_pw_flag    = 1'b0;
      next_oc         = OC_NONE;
      next_step_count = STEP_CNT_ZERO;
    end
    else
    begin
      if (word_take)
      begin
        next_coil_a     = rx_word.coil_a;
        next_coil_b     = rx_word.coil_b;
        next_step_pulse = 1'b1;
        next_step_count = step_count_out + STEP_CNT_ONE;
        if (coil_zero(rx_word.coil_a) && coil_zero(rx_word.coil_b))
        begin
          next_oc = OC_NONE;
        end
      end
      next_oc = next_oc | oc_s;
    end
    next_bridge_a = bridge_drive(next_state, next_coil_a, next_oc.low_a, next_oc.high);
    next_bridge_b = bridge_drive(next_state, next_coil_b, next_oc.low_b, next_oc.high);
    next_shutdown = (next_state == ST_OFF);
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state             <= ST_OFF;
      toggle_prev       <= 1'b0;
      coil_a_out        <= CLEAR_WORD.coil_a;
      coil_b_out        <= CLEAR_WORD.coil_b;
      bridge_a_on_out   <= 1'b0;
      bridge_b_on_out   <= 1'b0;
      shutdown_out      <= 1'b1;
      overtemp_flag_out <= 1'b0;
      prewarn_flag_out  <= 1'b0;
      oc_flags_out      <= OC_NONE;
      step_pulse_out    <= 1'b0;
      step_count_out    <= STEP_CNT_ZERO;
    end
    else
    begin
      state             <= next_state;
      toggle_prev       <= next_toggle_prev;
      coil_a_out        <= next_coil_a;
      coil_b_out        <= next_coil_b;
      bridge_a_on_out   <= next_bridge_a;
      bridge_b_on_out   <= next_bridge_b;
      shutdown_out      <= next_shutdown;
      overtemp_flag_out <= next_ot_flag;
      prewarn_flag_out  <= next_pw_flag;
      oc_flags_out      <= next_oc;
      step_pulse_out    <= next_step_pulse;
      step_count_out    <= next_step_count;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_HOT_BRIDGES_OFF: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    ot_s |=> (!bridge_a_on_out && !bridge_b_on_out))
    else $error("bridge on during overtemperature");

  AST_HOT_RESUME: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state == ST_HOT && !ot_s && !dis_s) |=> (state == ST_RUN))
    else $error("no resume after cool down");

  AST_OT_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (ot_s && !dis_s) |=> overtemp_flag_out ##0 (state == ST_HOT))
    else $error("overtemperature flag or state missing");

  AST_PREWARN_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    ##1 (prewarn_flag_out == ($past(pw_s) && !$past(dis_s))))
    else $error("prewarning flag wrong");

  AST_DISABLE_OFF: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    dis_s |=> (shutdown_out && !bridge_a_on_out && !bridge_b_on_out && state == ST_OFF))
    else $error("not shut down while disabled");

  AST_DISABLE_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    $rose(dis_s) |=> (coil_a_out == 6'h00 && coil_b_out == 6'h00 && oc_flags_out == OC_NONE
                      && !overtemp_flag_out && step_count_out == STEP_CNT_ZERO))
    else $error("state not cleared on disable");

  AST_ENABLE_LEVEL: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!dis_s && !ot_s) [*2] |=> !shutdown_out)
    else $error("still shut down while enabled");

  AST_ONE_STEP: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (word_take && !dis_s) |=> (step_pulse_out && step_count_out == $past(step_count_out) + 16'h0001)
                              ##1 !step_pulse_out)
    else $error("word did not make exactly one step");

  AST_FIELDS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (word_take && !dis_s) |=> (coil_a_out == $past(rx_word[11:6]) && coil_b_out == $past(rx_word[5:0])))
    else $error("coil fields not taken from word");

  AST_OC_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (word_take && !dis_s && oc_s == OC_NONE && rx_word.coil_a.magnitude == MAG_ZERO
     && rx_word.coil_b.magnitude == MAG_ZERO) |=> (oc_flags_out == OC_NONE))
    else $error("zero word left overcurrent flags set");

  COV_STEP: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    step_pulse_out && bridge_a_on_out);
  COV_HOT_RESUME: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state == ST_HOT) ##1 (state == ST_RUN));
  COV_OC_CLEAR: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (oc_flags_out != OC_NONE) ##1 (oc_flags_out == OC_NONE));
  COV_DISABLE: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state == ST_RUN) ##1 (state == ST_OFF));

endmodule : microstep_spi_command_and_protection

// [verification/spi_host_model.sv]
/*
  behavioural motion controller: builds coil words from a sine table and sends them framed.
  assumes mode 0 on the receiver; the link clock stands low outside frames.
*/
`timescale 1ns/1ps
module spi_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out
);
  // ----------------------------------------------------------------
  // sine table and phase state
  // ----------------------------------------------------------------
  logic [5:0]  sine_tab [64] = '{
    6'h00, 6'h02, 6'h06, 6'h08, 6'h0C, 6'h0E, 6'h10, 6'h14,
    6'h16, 6'h18, 6'h18, 6'h1A, 6'h1C, 6'h1C, 6'h1E, 6'h1E,
    6'h3E, 6'h3E, 6'h3E, 6'h3C, 6'h3C, 6'h3A, 6'h38, 6'h38,
    6'h36, 6'h34, 6'h30, 6'h2E, 6'h2C, 6'h28, 6'h26, 6'h22,
    6'h01, 6'h03, 6'h07, 6'h09, 6'h0D, 6'h0F, 6'h11, 6'h15,
    6'h17, 6'h19, 6'h19, 6'h1B, 6'h1D, 6'h1D, 6'h1F, 6'h1F,
    6'h3F, 6'h3F, 6'h3F, 6'h3D, 6'h3D, 6'h3B, 6'h39, 6'h39,
    6'h37, 6'h35, 6'h31, 6'h2F, 6'h2D, 6'h29, 6'h27, 6'h23};
  logic [5:0]  step_phase_index;
  logic [11:0] last_word;
  logic [11:0] decay_and_mask;
  logic [11:0] decay_or_mask;
  logic        busy;

  initial
  begin
    sck_out          = 1'b0;
    cs_n_out         = 1'b1;
    mosi_out         = 1'b0;
    step_phase_index = 6'h00;
    last_word        = 12'h000;
    decay_and_mask   = 12'hFFF;
    decay_or_mask    = 12'h000;
    busy             = 1'b0;
  end

  // ----------------------------------------------------------------
  // framed transfer of the top n bits, msb first
  // ----------------------------------------------------------------
  task send_word(input logic [11:0] w, input int n);
    int i;
    busy     = 1'b1;
    cs_n_out = 1'b0;
    #6;
    for (i = 11; i > 11 - n; i--)
    begin
      mosi_out = w[i];
      #6;
      sck_out = 1'b1;
      #6;
      sck_out = 1'b0;
    end
    #6;
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    busy     = 1'b0;
    if (n == 12)
      last_word = w;
  endtask : send_word

  // ----------------------------------------------------------------
  // one microstep in either direction
  // ----------------------------------------------------------------
  task step(input logic ccw);
    logic [11:0] decay_reverse_mask;
    logic [11:0] io_word;
    decay_reverse_mask = ccw ? 12'h820 : 12'h000;
    if (ccw)
      step_phase_index = step_phase_index - 6'h01;
    else
      step_phase_index = step_phase_index + 6'h01;
    io_word = {sine_tab[step_phase_index], sine_tab[step_phase_index + 6'h10]}
              ^ decay_reverse_mask;
    io_word = (io_word & decay_and_mask) | decay_or_mask;
    if (!busy)
      send_word(io_word, 12);
  endtask : step
endmodule : spi_host_model

// [verification/testbench.sv]
/*
  self-checking bench for the microstep command receiver and protection.
  assumes pins driven on the falling reference edge and words spaced well over 200 ns.
*/
`timescale 1ns/1ps
module testbench;
  import ustep_pkg::*;
  // ----------------------------------------------------------------
  // clock, pins and design
  // ----------------------------------------------------------------
  logic        ref_clk_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic        dis_pin    = 1'b0;
  logic        ot_pin     = 1'b0;
  logic        pw_pin     = 1'b0;
  oc_flags_t   oc_pin     = OC_NONE;
  logic        sck, cs_n, mosi;
  coil_field_t coil_a_out, coil_b_out;
  logic        bridge_a_on_out, bridge_b_on_out, shutdown_out;
  logic        overtemp_flag_out, prewarn_flag_out, step_pulse_out;
  oc_flags_t   oc_flags_out;
  logic [15:0] step_count_out;
  logic [15:0] exp_cnt = 16'h0000;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          k;

  always #20 ref_clk_in = ~ref_clk_in;

  spi_host_model host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi));

  microstep_spi_command_and_protection uut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .disable_input_low_active_in(dis_pin), .overtemp_in(ot_pin),
    .prewarn_in(pw_pin), .oc_event_in(oc_pin), .coil_a_out(coil_a_out),
    .coil_b_out(coil_b_out), .bridge_a_on_out(bridge_a_on_out),
    .bridge_b_on_out(bridge_b_on_out), .shutdown_out(shutdown_out),
    .overtemp_flag_out(overtemp_flag_out), .prewarn_flag_out(prewarn_flag_out),
    .oc_flags_out(oc_flags_out), .step_pulse_out(step_pulse_out),
    .step_count_out(step_count_out));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task set_pins(input logic dis, input logic ot, input logic pw, input oc_flags_t oc);
    @(negedge ref_clk_in);
    dis_pin = dis;
    ot_pin  = ot;
    pw_pin  = pw;
    oc_pin  = oc;
    repeat (5) @(negedge ref_clk_in);
  endtask : set_pins

  task wait_pulse(input logic [15:0] exp);
    int n;
    logic [15:0] seen;
    seen = 16'h0000;
    for (n = 0; n < 12; n++)
    begin
      @(posedge ref_clk_in);
      #1;
      if (step_pulse_out === 1'b1)
        seen = seen + 16'h0001;
    end
    check(seen, exp, "step pulses");
    check(step_count_out, exp_cnt, "step count");
  endtask : wait_pulse

  task check_coils(input logic en_a, input logic en_b);
    check(coil_a_out, host.last_word[11:6], "coil a");
    check(coil_b_out, host.last_word[5:0], "coil b");
    check(bridge_a_on_out, en_a & |host.last_word[10:7], "bridge a");
    check(bridge_b_on_out, en_b & |host.last_word[4:1], "bridge b");
  endtask : check_coils

  task tally_and_finish;
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge ref_clk_in);
    check(shutdown_out, 1'b1, "shutdown in reset");
    rstn_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    check(shutdown_out, 1'b0, "shutdown after reset");
    for (k = 0; k < 80; k++)
    begin
      host.step(k >= 70);
      exp_cnt++;
      wait_pulse(16'h0001);
      check_coils(1'b1, 1'b1);
    end
    host.send_word(12'hFFF, 7);
    wait_pulse(16'h0000);
    check_coils(1'b1, 1'b1);
    set_pins(1'b0, 1'b1, 1'b0, OC_NONE);
    check(overtemp_flag_out, 1'b1, "overtemp flag");
    check_coils(1'b0, 1'b0);
    host.step(1'b0);
    exp_cnt++;
    wait_pulse(16'h0001);
    check_coils(1'b0, 1'b0);
    set_pins(1'b0, 1'b0, 1'b1, OC_NONE);
    check(overtemp_flag_out, 1'b0, "overtemp flag off");
    check(prewarn_flag_out, 1'b1, "prewarn flag");
    check_coils(1'b1, 1'b1);
    set_pins(1'b0, 1'b0, 1'b0, 3'h4);
    check(prewarn_flag_out, 1'b0, "prewarn flag off");
    set_pins(1'b0, 1'b0, 1'b0, OC_NONE);
    check(oc_flags_out, 3'h4, "oc sticky");
    host.step(1'b0);
    exp_cnt++;
    wait_pulse(16'h0001);
    check(oc_flags_out, 3'h4, "oc kept by nonzero word");
    check_coils(1'b0, 1'b1);
    host.send_word(12'h821, 12);
    exp_cnt++;
    wait_pulse(16'h0001);
    check(oc_flags_out, OC_NONE, "oc cleared by zero word");
    check_coils(1'b1, 1'b1);
    host.step(1'b0);
    exp_cnt++;
    wait_pulse(16'h0001);
    set_pins(1'b0, 1'b1, 1'b1, 3'h1);
    set_pins(1'b1, 1'b1, 1'b1, 3'h1);
    exp_cnt = 16'h0000;
    check(shutdown_out, 1'b1, "shutdown while disabled");
    check({coil_a_out, coil_b_out}, WORD_ZERO, "coils cleared");
    check({overtemp_flag_out, prewarn_flag_out, oc_flags_out}, 5'h00, "flags");
    check({bridge_a_on_out, bridge_b_on_out}, 2'h0, "bridges off");
    check(step_count_out, exp_cnt, "count cleared");
    host.step(1'b0);
    wait_pulse(16'h0000);
    check({coil_a_out, coil_b_out}, WORD_ZERO, "word ignored");
    set_pins(1'b0, 1'b0, 1'b0, OC_NONE);
    check(shutdown_out, 1'b0, "enabled again");
    host.decay_or_mask = 12'h820;
    host.step(1'b0);
    exp_cnt++;
    wait_pulse(16'h0001);
    check_coils(1'b1, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
